// ===== hw/pcwcc_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Wait bit set lengthens a window's 16-bit cycles by one ISA wait.
// - Wait bit is ignored when the access runs 8 bits wide.
// - Zero-wait bit set shortens a window's 8-bit cycles to three host clocks.
// - Zero-wait bit is ignored when the access runs 16 bits wide.
// - Auto-size bit set takes width from card IOIS16, else fixed bit.
// - Fixed width bit zero means 8 bits, one means 16 bits.
// - Fixed width bit disregarded while the auto-size bit is set.
// - One control register per socket at 07h and 47h, memory at 807h.
// - Disabled window gets no acknowledge, whatever its sizing settings.
module pcwcc_ctrl
    import pcwcc_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // Indexed register port
    input  wire logic        i_idx_wr,
    input  wire logic        i_idx_rd,
    input  wire logic [7:0]  i_idx,
    // Memory-space register port, socket selected by i_mem_sock
    input  wire logic        i_mem_wr,
    input  wire logic        i_mem_rd,
    input  wire logic        i_mem_sock,
    input  wire logic [11:0] i_mem_ofs,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_rdata,
    output logic             o_rd_hit,
    // Host I/O cycle request
    input  wire logic        i_io_req,
    input  wire logic        i_io_sock,
    input  wire logic        i_io_win,
    input  wire logic        i_iois16,
    output logic             o_io_ack,
    output logic             o_io_busy,
    output logic             o_io_wide,
    output logic             o_io_done
);

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    function automatic logic [2:0] pcw_decode(input logic idx_acc, input logic [7:0] idx,
                                              input logic mem_acc, input logic sock,
                                              input logic [11:0] ofs);
        // {hit, socket, is_ctrl}
        logic [2:0] r;
        r = 3'h0;
        if (idx_acc)
        begin
            if (idx == SOCK_A_CTRL_IDX)        r = 3'h5;
            else if (idx == SOCK_B_CTRL_IDX)   r = 3'h7;
            else if (idx == SOCK_A_ENABLE_IDX) r = 3'h4;
            else if (idx == SOCK_B_ENABLE_IDX) r = 3'h6;
        end
        else if (mem_acc)
        begin
            if (ofs == MEM_CTRL_OFS)           r = {1'b1, sock, 1'b1};
            else if (ofs == MEM_ENABLE_OFS)    r = {1'b1, sock, 1'b0};
        end
        return r;
    endfunction : pcw_decode

    logic [7:0]  ctrl_r   [2];
    logic [7:0]  enable_r [2];
    logic [2:0]  wr_dec;
    logic [2:0]  rd_dec;

    assign wr_dec = pcw_decode(i_idx_wr, i_idx, i_mem_wr & ~i_idx_wr, i_mem_sock, i_mem_ofs);
    assign rd_dec = pcw_decode(i_idx_rd, i_idx, i_mem_rd & ~i_idx_rd, i_mem_sock, i_mem_ofs);

    // ----------------------------------------
    // Per-socket register copies
    // ----------------------------------------
    genvar s;
    generate
        for (s = 0; s < 2; s++)
        begin : g_sock
            always_ff @(posedge i_mclk)
            begin
                if (i_rst)
                begin
                    ctrl_r[s]   <= CTRL_RESET;
                    enable_r[s] <= ENABLE_RESET;
                end
                else if (wr_dec[2] && wr_dec[1] == 1'(s))
                begin
                    if (wr_dec[0])
                        ctrl_r[s] <= i_wdata;
                    else
                        enable_r[s] <= i_wdata & ENABLE_WMASK;
                end
            end
        end
    endgenerate

    // Read data held in flops; unmapped reads return zero, no hit
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            o_rdata  <= 8'h00;
            o_rd_hit <= 1'b0;
        end
        else
        begin
            o_rd_hit <= rd_dec[2];
            if (!rd_dec[2])
                o_rdata <= 8'h00;
            else if (rd_dec[0])
                o_rdata <= ctrl_r[rd_dec[1]];
            else
                o_rdata <= enable_r[rd_dec[1]];
        end
    end

    // ----------------------------------------
    // Width and length selection
    // ----------------------------------------
    logic [7:0] sel_ctrl;
    logic       win_en;
    logic       cyc_wide;
    logic [3:0] cyc_len;

    // Bit position of a field within the selected window's nibble
    function automatic logic [2:0] win_bit(input logic win, input int pos);
        return 3'(pos) + (win ? 3'(WIN_STRIDE) : 3'h0);
    endfunction : win_bit

    // Counts are host clocks, so ISA-equivalent timing scales with the host clock
    // Settings and IOIS16 only matter at the acknowledge edge
    always_comb
    begin
        sel_ctrl = ctrl_r[i_io_sock];
        win_en   = enable_r[i_io_sock][3'(WIN0_ENABLE_BIT) + {2'h0, i_io_win}];
        // Auto-size masks the fixed bit entirely
        if (sel_ctrl[win_bit(i_io_win, AUTO_SIZE_BIT)])
            cyc_wide = i_iois16;
        else
            cyc_wide = sel_ctrl[win_bit(i_io_win, FIXED_WIDTH_BIT)];
        // Each timing bit is read only in the branch of the width it governs
        if (cyc_wide)
        begin
            if (sel_ctrl[win_bit(i_io_win, WIDE_WAIT_BIT)])
                cyc_len = STD_WIDE_CYC + ISA_WAIT_CYC;
            else
                cyc_len = STD_WIDE_CYC;
        end
        else
        begin
            if (sel_ctrl[win_bit(i_io_win, NARROW_SHORT_BIT)])
                cyc_len = SHORT_NARROW_CYC;
            else
                cyc_len = STD_NARROW_CYC;
        end
    end

    // ----------------------------------------
    // Cycle sequencer
    // ----------------------------------------
    pcw_state_e  state_r;
    logic [3:0]  cnt_r;
    logic        io_start;

    // Acknowledge only from idle, so a request during a running cycle just waits
    assign io_start = (state_r == PCW_IDLE) & i_io_req & win_en;

    // Done stands one clock; the next request is taken the clock after
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            state_r <= PCW_IDLE;
        else
        begin
            case (state_r)
                PCW_IDLE:
                begin
                    if (io_start)
                        state_r <= PCW_RUN;
                end
                PCW_RUN:
                begin
                    if (cnt_r == 4'h0)
                        state_r <= PCW_DONE;
                end
                PCW_DONE:
                    state_r <= PCW_IDLE;
                default:
                    state_r <= PCW_IDLE;
            endcase
        end
    end

    // Clocks left in the running cycle, loaded at the acknowledge edge
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            cnt_r <= 4'h0;
        else if (io_start)
            cnt_r <= cyc_len - 4'h1;
        else if (state_r == PCW_RUN && cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
    end

    // Width latched at start so a mid-cycle register write cannot change it
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            o_io_wide <= 1'b0;
        else if (io_start)
            o_io_wide <= cyc_wide;
    end

    // ----------------------------------------
    // Handshake outputs
    // ----------------------------------------
    assign o_io_ack  = io_start;
    assign o_io_busy = (state_r == PCW_RUN);
    assign o_io_done = (state_r == PCW_DONE);

endmodule : pcwcc_ctrl

// ===== hw/pcwcc_pkg.sv
package pcwcc_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0]  SOCK_A_CTRL_IDX   = 8'h07;
    localparam logic [7:0]  SOCK_B_CTRL_IDX   = 8'h47;
    localparam logic [7:0]  SOCK_A_ENABLE_IDX = 8'h06;
    localparam logic [7:0]  SOCK_B_ENABLE_IDX = 8'h46;
    localparam logic [11:0] MEM_CTRL_OFS      = 12'h807;
    localparam logic [11:0] MEM_ENABLE_OFS    = 12'h806;
    localparam logic [7:0]  CTRL_RESET        = 8'h00;
    localparam logic [7:0]  ENABLE_RESET      = 8'h00;

    // ----------------------------------------
    // Field positions, window 0; window 1 adds WIN_STRIDE to control fields, one to the enable bit
    // ----------------------------------------
    localparam int FIXED_WIDTH_BIT  = 0;
    localparam int AUTO_SIZE_BIT    = 1;
    localparam int NARROW_SHORT_BIT = 2;
    localparam int WIDE_WAIT_BIT    = 3;
    localparam int WIN_STRIDE       = 4;
    localparam int WIN0_ENABLE_BIT  = 6;
    localparam logic [7:0] ENABLE_WMASK = 8'hdf;

    // ----------------------------------------
    // Cycle timing in host clocks
    // ----------------------------------------
    localparam logic [3:0] STD_NARROW_CYC = 4'h6;
    localparam logic [3:0] STD_WIDE_CYC   = 4'h3;
    localparam logic [3:0] SHORT_NARROW_CYC = 4'h3;
    localparam logic [3:0] ISA_WAIT_CYC   = 4'h2;

    typedef enum logic [1:0] {
        PCW_IDLE,
        PCW_RUN,
        PCW_DONE
    } pcw_state_e;

endpackage : pcwcc_pkg

// ===== testbench/pcwcc_properties.sv
`timescale 1ns/1ps
module pcwcc_properties (
    input wire logic       i_mclk, i_rst, i_idx_rd, i_mem_rd, i_io_req,
    input wire logic       o_rd_hit, o_io_ack, o_io_busy, o_io_wide, o_io_done,
    input wire logic [7:0] o_rdata
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // Shortest cycle is three clocks, longest six
    sequence s_run;
        o_io_busy [*3] ##[1:4] o_io_done;
    endsequence
    chk_run_len: assert property ($rose(o_io_busy) |-> s_run)
        else $error("cycle length out of range");
    chk_ack_start: assert property (o_io_ack |=> o_io_busy && !o_io_done)
        else $error("ack not followed by busy");
    chk_no_ack_run: assert property (o_io_busy |-> !o_io_ack)
        else $error("ack during running cycle");
    chk_done_once: assert property (o_io_done |=> !o_io_done && !o_io_busy)
        else $error("done not a single pulse");
    chk_ack_req: assert property (o_io_ack |-> i_io_req)
        else $error("ack without request");
    chk_rd_miss: assert property (!o_rd_hit |-> o_rdata == 8'h00)
        else $error("read data without hit");
    chk_rd_cause: assert property (o_rd_hit |-> $past(i_idx_rd || i_mem_rd))
        else $error("hit without read strobe");
    chk_wide_hold: assert property (!o_io_ack |=> $stable(o_io_wide))
        else $error("width changed without start");
    chk_reset_idle: assert property ($fell(i_rst) |-> !o_io_busy && !o_rd_hit)
        else $error("not idle after reset");
endmodule : pcwcc_properties
bind pcwcc_ctrl pcwcc_properties pcwcc_properties_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_idx_rd(i_idx_rd),
    .i_mem_rd(i_mem_rd), .i_io_req(i_io_req), .o_rd_hit(o_rd_hit), .o_io_ack(o_io_ack),
    .o_io_busy(o_io_busy), .o_io_wide(o_io_wide), .o_io_done(o_io_done), .o_rdata(o_rdata));

// ===== testbench/pcwcc_card.sv
`timescale 1ns/1ps
module pcwcc_card (
    input  wire logic i_mclk,
    input  wire logic i_sel,
    input  wire logic i_wide,
    output logic      o_iois16
);
    logic idle_r = 1'b0;
    // Unaddressed card leaves the line wandering
    always @(posedge i_mclk) idle_r <= !idle_r;
    assign o_iois16 = i_sel ? i_wide : idle_r;
endmodule : pcwcc_card

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic i_mclk = 0, i_rst = 1, i_idx_wr = 0, i_idx_rd = 0, i_mem_wr = 0, i_mem_rd = 0, i_mem_sock = 0;
    logic i_io_req = 0, i_io_sock = 0, i_io_win = 0, wide = 0, i_iois16;
    logic o_rd_hit, o_io_ack, o_io_busy, o_io_wide, o_io_done;
    logic [7:0] i_idx = 0, i_wdata = 0, o_rdata;
    logic [11:0] i_mem_ofs = 0;
    logic [31:0] seed = 32'hce127e60, r;
    logic hung = 0;
    int ctl[2] = '{0, 0}, en[2] = '{0, 0}, errors = 0, checked = 0, n;
    initial forever #25 i_mclk = ~i_mclk;
    pcwcc_ctrl pcwcc_ctrl_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_idx_wr(i_idx_wr), .i_idx_rd(i_idx_rd),
        .i_idx(i_idx), .i_mem_wr(i_mem_wr), .i_mem_rd(i_mem_rd), .i_mem_sock(i_mem_sock), .i_mem_ofs(i_mem_ofs),
        .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rd_hit(o_rd_hit), .i_io_req(i_io_req), .i_io_sock(i_io_sock),
        .i_io_win(i_io_win), .i_iois16(i_iois16), .o_io_ack(o_io_ack), .o_io_busy(o_io_busy),
        .o_io_wide(o_io_wide), .o_io_done(o_io_done));
    pcwcc_card pcwcc_card_i (.i_mclk(i_mclk), .i_sel(i_io_req), .i_wide(wide), .o_iois16(i_iois16));
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task close_out();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    // Either port reaches the same register copy
    task acc(input logic mem, input logic rd, input logic s, input logic [7:0] ix, input logic [7:0] d);
        @(negedge i_mclk);
        i_idx = ix | {1'b0, s, 6'h00};
        i_mem_sock = s;
        i_mem_ofs = {4'h8, ix};
        i_wdata = d;
        {i_idx_wr, i_idx_rd, i_mem_wr, i_mem_rd} = {!mem && !rd, !mem && rd, mem && !rd, mem && rd};
        @(negedge i_mclk);
        {i_idx_wr, i_idx_rd, i_mem_wr, i_mem_rd} = 4'h0;
        if (rd) chk(o_rdata, 8'(ix == 8'h07 ? ctl[s] : ix == 8'h06 ? en[s] : 0));
        if (rd) chk({7'h00, o_rd_hit}, {7'h00, ix == 8'h07 || ix == 8'h06});
        else if (ix == 8'h07) ctl[s] = d;
        else if (ix == 8'h06) en[s] = d & 8'hdf;
    endtask : acc
    task io(input logic s, input logic w);
        int len;
        logic wd;
        wd = ctl[s][4*w+1] ? wide : ctl[s][4*w];
        len = wd ? (ctl[s][4*w+3] ? 5 : 3) : (ctl[s][4*w+2] ? 3 : 6);
        @(negedge i_mclk);
        {i_io_req, i_io_sock, i_io_win} = {1'b1, s, w};
        #1;
        for (n = 0; n < 8 && o_io_ack !== 1'b1; n++) @(negedge i_mclk);
        chk({7'h00, o_io_ack}, {7'h00, en[s][6+w]});
        @(negedge i_mclk);
        i_io_req = 0;
        for (n = 0; n < 9 && o_io_busy === 1'b1; n++) @(negedge i_mclk);
        if (n == 9)
        begin
            errors++;
            hung = 1;
        end
        if (en[s][6+w]) chk(8'(n), 8'(len));
        if (en[s][6+w]) chk({6'h00, o_io_done, o_io_wide}, {6'h00, 1'b1, wd});
    endtask : io
    initial
    begin
        repeat (5) @(negedge i_mclk);
        i_rst = 0;
        for (int k = 0; k < 4; k++) acc(k[1], 1, k[0], 8'h06 + k[1], 8'h00);
        io(0, 0);
        for (int it = 0; it < 80 && !hung; it++)
        begin
            r = xs();
            wide = r[0];
            acc(r[1], 0, r[2], 8'h07, r[15:8]);
            acc(r[3], 0, r[2], 8'h06, r[23:16]);
            acc(r[4], r[30], r[5], {2'h0, r[29:24]}, r[31:24]);
            acc(r[6], 1, r[2], 8'h07, 8'h00);
            io(r[2], r[7]);
        end
        close_out();
    end
endmodule : tb_top
